// ===== rtl/tag_cmd.sv
// Type B tag command handler: ATTRIB tail checks, halt, file SELECT.
// Assumes a framing layer that delivers bytes, flags frame end with CRC
// status and appends CRC_B to the reply bytes that this block emits.
// Operation
// - ATTRIB Param3 must be zero upper nibble and the protocol type low.
// - ATTRIB Param4 upper nibble is ignored and a nonzero low one is mute.
// - An accepted ATTRIB is answered with one byte 0x10 before CRC_B.
// - HLTB with code 0x50 and the matching PUPI halts the tag.
// - An accepted HLTB is answered with one byte 0x00 before CRC_B.
// - SELECT (INS 0xA4) accepts only class 0x00, else error status.
// - Only P1/P2 of 0x020C, 0x0400 and 0x000C are accepted.
// - Lc must be 7 for the application and 2 for all else.
// - Application data must be exactly D2760000850101.
// - Under 0x000C, E103 picks the CC file and 0103 the NDEF file.
// - Under 0x020C any two-byte identifier selects an EF file.
// - Le of 0x00 may appear only in application selection.
// - With P2 of 0x0C the reply is only SW1 and SW2.
`include "tagcmd_regs.svh"
`default_nettype none
module tag_cmd
  import tagcmd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire rx_byte_s rx,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic [31:0] pupi,
  input wire logic [3:0] proto_type,
  output tx_byte_s tx,
  output logic halted,
  output logic active,
  output sel_e selected
);

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  logic [7:0] buf_r [`MAX_BYTES];
  logic [4:0] cnt_r;
  logic [7:0] b0, b1, b2, b3, b4, b5, b6;

  // Store up to sixteen bytes; frame end rewinds the count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 5'h00;
    end else if (rx_end) begin
      cnt_r <= 5'h00;
    end else if (rx.valid && cnt_r != `MAX_BYTES) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `MAX_BYTES; gi++) begin : g_buf
      // One stored byte per slot
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          buf_r[gi] <= 8'h00;
        end else if (rx.valid && !rx_end && cnt_r == 5'(gi)) begin
          buf_r[gi] <= rx.data;
        end
      end
    end
  endgenerate

  assign b0 = buf_r[0];
  assign b1 = buf_r[1];
  assign b2 = buf_r[2];
  assign b3 = buf_r[3];
  assign b4 = buf_r[4];
  assign b5 = buf_r[5];
  assign b6 = buf_r[6];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [31:0] id_w;
  logic [15:0] p12_w;
  logic [55:0] app_w;
  logic [15:0] fid_w;
  logic is_attrib, is_halt, is_sel, attrib_ok, halt_ok;
  logic sel_ok, le_ok, lc_ok, data_ok;
  sel_e sel_nxt;

  assign id_w = {b1, b2, b3, b4};
  assign p12_w = {b2, b3};
  assign app_w = {b5, b6, buf_r[7], buf_r[8], buf_r[9], buf_r[10],
                  buf_r[11]};
  assign fid_w = {b5, b6};
  // Frame kinds by length; the framing layer strips CRC_B
  assign is_attrib = cnt_r == `LEN_ATTRIB && b0 == `CMD_ATTRIB;
  assign is_halt = cnt_r == `LEN_HALT && b0 == `CMD_HALT;
  assign is_sel = cnt_r >= `LEN_SEL_MIN && b1 == `APDU_INS_SELECT;
  // Param3 fixed nibble plus protocol type; Param4 low nibble zero
  logic b7_hi_ok, b7_lo_ok, b8_ok;
  assign b7_hi_ok = buf_r[`POS_PARAM3][7:4] == `NIB_ZERO;
  assign b7_lo_ok = buf_r[`POS_PARAM3][3:0] == proto_type;
  assign b8_ok = buf_r[`POS_PARAM4][3:0] == `NIB_ZERO;
  assign attrib_ok = id_w == pupi && b7_hi_ok && b7_lo_ok && b8_ok;
  assign halt_ok = id_w == pupi;

  // Length, data and Le checks per selection kind
  always_comb begin
    lc_ok = 1'b0;
    data_ok = 1'b0;
    le_ok = 1'b0;
    sel_nxt = SEL_NONE;
    case (p12_w)
      `P12_APP: begin
        lc_ok = b4 == `LC_APP;
        data_ok = app_w == `APP_ID;
        le_ok = cnt_r == `LEN_APP ||
                (cnt_r == `LEN_APP_LE && buf_r[`POS_LE] == `LE_APP);
        sel_nxt = SEL_APP;
      end
      `P12_FILE: begin
        lc_ok = b4 == `LC_FILE;
        le_ok = cnt_r == `LEN_FILE;
        data_ok = fid_w == `FID_CC || fid_w == `FID_NDEF;
        sel_nxt = fid_w == `FID_CC ? SEL_CC : SEL_NDEF;
      end
      `P12_EF: begin
        lc_ok = b4 == `LC_FILE;
        le_ok = cnt_r == `LEN_FILE;
        data_ok = 1'b1;
        sel_nxt = SEL_EF;
      end
      default: begin
        lc_ok = 1'b0;
      end
    endcase
  end
  assign sel_ok = b0 == `APDU_CLA && lc_ok && data_ok && le_ok;

  // ----------------------------------------------------------------
  // Reply sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, ONE, SW1, SW2} st_e;
  st_e st_r;
  logic [7:0] one_r;
  logic [15:0] sw_r;
  logic go;
  assign go = rx_end && rx_crc_ok;

  // Choose reply at frame end, then stream it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= IDLE;
      one_r <= 8'h00;
      sw_r <= 16'h0000;
    end else begin
      case (st_r)
        IDLE: begin
          if (go && is_attrib && attrib_ok && !halted) begin
            one_r <= `ATTRIB_ANSWER;
            st_r <= ONE;
          end else if (go && is_halt && halt_ok && !halted) begin
            one_r <= `HALT_ANSWER;
            st_r <= ONE;
          end else if (go && is_sel && active) begin
            sw_r <= sel_ok ? `SW_OK : `SW_ERR;
            st_r <= SW1;
          end
        end
        ONE: st_r <= IDLE;
        SW1: st_r <= SW2;
        SW2: st_r <= IDLE;
        default: st_r <= IDLE;
      endcase
    end
  end

  // Reply byte register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx <= '0;
    end else begin
      case (st_r)
        ONE: tx <= '{valid: 1'b1, last: 1'b1, data: one_r};
        SW1: tx <= '{valid: 1'b1, last: 1'b0, data: sw_r[15:8]};
        SW2: tx <= '{valid: 1'b1, last: 1'b1, data: sw_r[7:0]};
        default: tx <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Tag state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      halted <= 1'b0;
      active <= 1'b0;
      selected <= SEL_NONE;
    end else if (st_r == IDLE && go && !halted) begin
      if (is_halt && halt_ok) begin
        halted <= 1'b1;
        active <= 1'b0;
      end else if (is_attrib && attrib_ok) begin
        active <= 1'b1;
      end else if (is_sel && active && sel_ok) begin
        selected <= sel_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_CRC_MUTE: assert property (@(posedge clk) disable iff (!rstn)
    rx_end && !rx_crc_ok && st_r == IDLE |=> st_r == IDLE)
    else $error("reply started on bad crc");
  AST_ATTRIB_BYTE: assert property (@(posedge clk) disable iff (!rstn)
    st_r == IDLE && go && is_attrib && attrib_ok && !halted
    |=> ##1 tx.valid && tx.data == `ATTRIB_ANSWER)
    else $error("attrib answer wrong");
  AST_P4_MUTE: assert property (@(posedge clk) disable iff (!rstn)
    st_r == IDLE && go && is_attrib &&
    buf_r[`POS_PARAM4][3:0] != `NIB_ZERO |=> st_r == IDLE)
    else $error("answered bad param4");
  AST_P3_MUTE: assert property (@(posedge clk) disable iff (!rstn)
    st_r == IDLE && go && is_attrib &&
    (buf_r[`POS_PARAM3][7:4] != `NIB_ZERO ||
    buf_r[`POS_PARAM3][3:0] != proto_type) |=> st_r == IDLE)
    else $error("answered bad param3");
  AST_HALT: assert property (@(posedge clk) disable iff (!rstn)
    st_r == IDLE && go && is_halt && halt_ok && !halted
    |=> halted ##1 tx.data == `HALT_ANSWER && tx.last)
    else $error("halt not taken");
  AST_CLA: assert property (@(posedge clk) disable iff (!rstn)
    st_r == IDLE && go && is_sel && active && b0 != `APDU_CLA
    |=> ##1 tx.valid && tx.data != `SW1_OK)
    else $error("bad class accepted");
  AST_SW_PAIR: assert property (@(posedge clk) disable iff (!rstn)
    st_r == SW1 |=> tx.valid && !tx.last ##1 tx.valid && tx.last)
    else $error("status words malformed");
  AST_P12: assert property (@(posedge clk) disable iff (!rstn)
    st_r == IDLE && go && is_sel && active && p12_w != `P12_EF &&
    p12_w != `P12_APP && p12_w != `P12_FILE
    |=> $stable(selected) && sw_r != `SW_OK)
    else $error("bad p1p2 accepted");

endmodule : tag_cmd
`default_nettype wire

// ===== rtl/tagcmd_regs.svh
// Constants for the Type B tag command handler: codes, lengths, fields.
// Assumes inclusion by the handler module only.
`ifndef TAGCMD_REGS_SVH
`define TAGCMD_REGS_SVH

`define CMD_ATTRIB 8'h1D
`define CMD_HALT 8'h50
`define APDU_CLA 8'h00
`define APDU_INS_SELECT 8'hA4
`define P12_EF 16'h020C
`define P12_APP 16'h0400
`define P12_FILE 16'h000C
`define P2_NO_FCI 8'h0C
`define LC_APP 8'h07
`define LC_FILE 8'h02
`define LE_APP 8'h00
`define APP_ID 56'hD2760000850101
`define FID_CC 16'hE103
`define FID_NDEF 16'h0103
`define ATTRIB_ANSWER 8'h10
`define HALT_ANSWER 8'h00
`define NIB_ZERO 4'h0
`define SW_OK 16'h9000
`define SW_ERR 16'h6A82
`define MAX_BYTES 5'h10
`define SW1_OK 8'h90
// Frame lengths in bytes, CRC_B excluded
`define LEN_ATTRIB 5'h09
`define LEN_HALT 5'h05
`define LEN_SEL_MIN 5'h05
`define LEN_FILE 5'h07
`define LEN_APP 5'h0C
`define LEN_APP_LE 5'h0D
// Byte positions inside a frame
`define POS_PARAM3 4'h7
`define POS_PARAM4 4'h8
`define POS_LE 4'hC

`endif

// ===== rtl/tagcmd_pkg.sv
// Types shared by the tag command handler.
// Assumes tagcmd_regs.svh is on the include path.
`default_nettype none
package tagcmd_pkg;
  // Byte stream from the framing layer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_s;
  // Reply byte toward the framing layer
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } tx_byte_s;
  // Selected file
  typedef enum logic [2:0] {
    SEL_NONE, SEL_APP, SEL_CC, SEL_NDEF, SEL_EF
  } sel_e;
endpackage : tagcmd_pkg
`default_nettype wire

// ===== testbench/reader_model.sv
// Reader model: sends command bytes and frame ends to the tag handler.
// Assumes the handler's clock; CRC status comes with each frame end.
`default_nettype none
module reader_model
  import tagcmd_pkg::*;
(
  input wire logic clk,
  output rx_byte_s rx,
  output logic rx_end,
  output logic rx_crc_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx = '{1'b0, 8'hA5};
    rx_end = 1'b0;
    rx_crc_ok = 1'b0;
  end
  // Bytes on back-to-back edges, then the end strobe
  task automatic send(input logic [7:0] b[$], input logic ok);
    foreach (b[i]) begin
      @(posedge clk);
      rx <= '{1'b1, b[i]};
    end
    @(posedge clk);
    rx <= '{1'b0, ~rx.data}; // Stale byte inverted
    rx_end <= 1'b1;
    rx_crc_ok <= ok;
    @(posedge clk);
    rx_end <= 1'b0;
    rx_crc_ok <= ~ok;
  endtask : send
endmodule : reader_model
`default_nettype wire

// ===== testbench/type_b_tag_command_handler_tb.sv
// Bench for the tag command handler; replies checked from a queue.
// Assumes the package and the reader model are compiled first.
`default_nettype none
module type_b_tag_command_handler_tb
  import tagcmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] pupi;
  logic [3:0] proto_type;
  rx_byte_s rx;
  logic rx_end, rx_crc_ok, halted, active;
  tx_byte_s tx;
  sel_e selected;
  logic [8:0] exp_q[$];
  logic [7:0] f[$];
  logic [7:0] cla = 8'h00;
  logic crc_ok = 1'b1;
  logic [15:0] ef_id;
  int bad_count = 0;
  int tests_run = 0;
  int seed = 32'hd1e31f1e;
  always #20 clk = ~clk;
  reader_model reader_u (.clk(clk), .rx(rx), .rx_end(rx_end),
    .rx_crc_ok(rx_crc_ok));
  tag_cmd dut_u (.clk(clk), .rstn(rstn), .rx(rx), .rx_end(rx_end),
    .rx_crc_ok(rx_crc_ok), .pupi(pupi), .proto_type(proto_type),
    .tx(tx), .halted(halted), .active(active), .selected(selected));
  task automatic fail(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) fail(m);
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Each reply byte against the oldest note
  always @(posedge clk) begin
    if (tx.valid === 1'b1) begin
      tests_run++;
      if (exp_q.size() == 0) fail("reply byte not expected");
      else if ({tx.last, tx.data} !== exp_q.pop_front())
        fail("reply byte");
    end
  end
  // Send f, wait for the reply to drain, then a quiet gap
  task automatic frame(input logic ok);
    int n;
    reader_u.send(f, ok);
    n = 0;
    while (exp_q.size() != 0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      fail("reply timeout");
      report_and_stop();
    end
    repeat (6) @(posedge clk);
  endtask : frame
  // ATTRIB or HLTB, CRC_B stripped by framing; ans < 0 means silence
  task automatic tagcmd(input logic [7:0] code, input logic [31:0] id,
    input logic [7:0] p3, p4, input logic ok, input int ans);
    f = {code, id[31:24], id[23:16], id[15:8], id[7:0]};
    if (code == 8'h1D) f = {f, 8'h00, 8'h08, p3, p4};
    if (ans >= 0) exp_q.push_back({1'b1, ans[7:0]});
    frame(ok);
  endtask : tagcmd
  // SELECT; sw of zero means silence, le < 0 means no Le byte
  task automatic sel(input logic [15:0] p12, input logic [7:0] lc,
    input logic [55:0] d, input int nd, le, input logic [15:0] sw,
    input sel_e want);
    f = {cla, 8'hA4, p12[15:8], p12[7:0], lc};
    for (int i = nd - 1; i >= 0; i--) f.push_back(d[8*i +: 8]);
    if (le >= 0) f.push_back(le[7:0]);
    if (sw != 16'h0) exp_q.push_back({1'b0, sw[15:8]});
    if (sw != 16'h0) exp_q.push_back({1'b1, sw[7:0]});
    frame(crc_ok);
    if (sw == 16'h9000) check(selected === want, "selected file");
  endtask : sel
  // ----------------------------
  // Main sequence
  // ----------------------------
  initial begin
    pupi = $random(seed);
    // Keep the second byte of halt frames clear of the select code
    if (pupi[31:24] == 8'hA4 || pupi[31:24] == 8'h5B) pupi[31:24] = 8'h3C;
    proto_type = 4'($random(seed));
    ef_id = {4'h2, 12'($random(seed))};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    sel(16'h000C, 8'h02, 56'hE103, 2, -1, 16'h0, SEL_NONE);
    check(selected === SEL_NONE, "select before attrib");
    tagcmd(8'h1D, pupi, {4'h1, proto_type}, 8'h00, 1'b1, -1);
    tagcmd(8'h1D, pupi, {4'h0, ~proto_type}, 8'h00, 1'b1, -1);
    tagcmd(8'h1D, pupi, {4'h0, proto_type}, 8'h01, 1'b1, -1);
    tagcmd(8'h1D, pupi, {4'h0, proto_type}, 8'h00, 1'b0, -1);
    check(active === 1'b0, "attrib refused");
    tagcmd(8'h1D, pupi, {4'h0, proto_type}, 8'hA0, 1'b1, 8'h10);
    check(active === 1'b1, "attrib taken");
    sel(16'h000C, 8'h02, 56'hE103, 2, -1, 16'h9000, SEL_CC);
    sel(16'h000C, 8'h02, 56'h0103, 2, -1, 16'h9000, SEL_NDEF);
    sel(16'h020C, 8'h02, 56'(ef_id), 2, -1, 16'h9000, SEL_EF);
    sel(16'h0400, 8'h07, 56'hD2760000850101, 7, 0, 16'h9000, SEL_APP);
    sel(16'h020C, 8'h02, 56'hE103, 2, 0, 16'h6A82, SEL_APP);
    sel(16'h0400, 8'h07, 56'hD2760000850101, 7, 1, 16'h6A82, SEL_APP);
    sel(16'h0400, 8'h07, 56'hD2760000850102, 7, -1, 16'h6A82, SEL_APP);
    sel(16'h0400, 8'h02, 56'hE103, 2, -1, 16'h6A82, SEL_APP);
    sel(16'h000C, 8'h03, 56'hE10300, 3, -1, 16'h6A82, SEL_APP);
    sel(16'h0100, 8'h02, 56'hE103, 2, -1, 16'h6A82, SEL_APP);
    cla = 8'h80;
    sel(16'h000C, 8'h02, 56'hE103, 2, -1, 16'h6A82, SEL_APP);
    cla = 8'h00;
    crc_ok = 1'b0;
    sel(16'h000C, 8'h02, 56'hE103, 2, -1, 16'h0, SEL_APP);
    crc_ok = 1'b1;
    tagcmd(8'h50, ~pupi, 8'h00, 8'h00, 1'b1, -1);
    check(halted === 1'b0, "halt with wrong id");
    tagcmd(8'h50, pupi, 8'h00, 8'h00, 1'b1, 8'h00);
    check(halted === 1'b1, "halt state");
    sel(16'h000C, 8'h02, 56'hE103, 2, -1, 16'h0, SEL_NONE);
    report_and_stop();
  end
endmodule : type_b_tag_command_handler_tb
`default_nettype wire
